// >>> rtl/dcp_host_port.sv
`timescale 1ns/10ps
`include "dcp_params.svh"

module dcp_host_port
  import dcp_pkg::*;
#(
  parameter int STEP_READY_CYCLES = `DCP_STEP_READY_CYC,
  parameter int UNLOAD_REVS = `DCP_UNLOAD_REVS
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic [7:0] i_port_select_bus_n,
  input wire logic [7:0] i_host_write_bus_n,
  input wire logic i_write_strobe,
  input wire logic i_read_strobe_n,
  input wire logic i_bootstrap_n,
  input wire logic i_controller_restart_n,
  input wire logic i_drive_zero_write_inhibit,
  input wire logic i_drive_fault,
  input wire logic i_track_zero,
  input wire logic i_index_pulse,
  input wire logic i_sector_valid,
  input wire logic [7:0] i_sector_number,
  input wire dcp_result_type i_result,
  output logic [7:0] o_host_read_bus,
  output logic o_host_read_oe,
  output logic o_operation_finished_n,
  output logic [1:0] o_drive_select,
  output logic o_step_pulse,
  output logic o_step_toward_inner,
  output logic o_fault_reset,
  output logic o_read_start,
  output logic o_write_start,
  output logic o_boot_read,
  output logic o_head_loaded,
  output logic [15:0] o_dma_address
);

  // ****************************************************************
  // strobe and address decode
  // ****************************************************************
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  dcp_command_type wr_cmd;
  dcp_command_type cmd;
  dcp_command_type next_cmd;
  dcp_status_type status_word;
  dcp_state_type state;
  dcp_state_type next_state;
  logic [7:0] dev_addr;
  logic prev_wr;
  logic prev_boot_n;
  logic wr_edge;
  logic boot_edge;
  logic cmd_load;
  logic dma_lo_load;
  logic dma_hi_load;
  logic rd_sel;
  logic restart;
  logic [1:0] eff_sel;
  logic write_blocked;
  logic start_read;
  logic start_write;

  // select and write buses are active low on the wire, decode on true levels
  assign dev_addr = ~i_port_select_bus_n;
  assign wr_cmd = dcp_command_type'(~i_host_write_bus_n);
  assign restart = ~i_controller_restart_n;
  assign wr_edge = i_write_strobe & ~prev_wr;
  assign boot_edge = prev_boot_n & ~i_bootstrap_n;
  assign cmd_load = wr_edge & addr_hit(dev_addr, `DCP_ADDR_CMD);
  assign dma_lo_load = wr_edge & addr_hit(dev_addr, `DCP_ADDR_DMA_LO);
  assign dma_hi_load = wr_edge & addr_hit(dev_addr, `DCP_ADDR_DMA_HI);
  assign rd_sel = ~i_read_strobe_n
                  & addr_hit(dev_addr, `DCP_ADDR_CMD);
  assign start_read = cmd_load & wr_cmd.read;
  assign start_write = cmd_load & wr_cmd.write & ~wr_cmd.read;
  // a write names the drive it also selects
  assign eff_sel = wr_cmd.sel_en ? {wr_cmd.sel_hi, wr_cmd.sel_lo}
                                 : o_drive_select;
  assign write_blocked = i_drive_zero_write_inhibit
                         & (eff_sel == 2'h0);

  // edge history of write strobe and bootstrap
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      prev_wr <= 1'b0;
      prev_boot_n <= 1'b1;
    end
    else if (i_ce)
    begin
      prev_wr <= i_write_strobe;
      prev_boot_n <= i_bootstrap_n;
    end
  end

  // ****************************************************************
  // operation sequencer
  // ****************************************************************
  logic boot_pending;
  logic next_boot_pending;
  logic op_write;
  logic next_op_write;
  logic illegal;
  logic next_illegal;
  logic op_end;
  logic op_go;
  logic next_read_start;
  logic next_write_start;
  logic next_boot_read;
  logic op_abort;

  // start, abort and finish of read, write and boot loads
  always_comb
  begin
    next_state = state;
    next_boot_pending = boot_pending | boot_edge;
    next_op_write = op_write;
    next_illegal = illegal;
    op_end = 1'b0;
    op_go = 1'b0;
    op_abort = 1'b0;
    next_read_start = 1'b0;
    next_write_start = 1'b0;
    next_boot_read = 1'b0;
    unique case (state)
      DCP_IDLE:
      begin
        if (boot_pending)
        begin
          next_state = DCP_BOOT;
          next_boot_pending = boot_edge;
          next_boot_read = 1'b1;
          next_op_write = 1'b0;
          op_go = 1'b1;
        end
        else if (start_read)
        begin
          next_state = DCP_BUSY;
          next_read_start = 1'b1;
          next_op_write = 1'b0;
          op_go = 1'b1;
        end
        else if (start_write && write_blocked)
          op_end = 1'b1;
        else if (start_write)
        begin
          next_state = DCP_BUSY;
          next_write_start = 1'b1;
          next_op_write = 1'b1;
          op_go = 1'b1;
        end
      end
      DCP_BOOT, DCP_BUSY:
      begin
        if (i_sector_valid && i_sector_number > `DCP_MAX_SECTOR)
          next_illegal = 1'b1;
        // id crc aborts only a write
        op_abort = i_result.track_mismatch
                   | (i_result.id_crc_err & op_write);
        if (op_abort || (i_result.op_done && !next_illegal))
        begin
          next_state = DCP_IDLE;
          next_illegal = 1'b0;
          op_end = 1'b1;
        end
      end
    endcase
    if (restart)
    begin
      next_state = DCP_IDLE;
      next_boot_pending = 1'b1;
      next_illegal = 1'b0;
      next_op_write = 1'b0;
      op_end = 1'b0;
      op_go = 1'b0;
      next_read_start = 1'b0;
      next_write_start = 1'b0;
      next_boot_read = 1'b0;
    end
  end

  // sequencer registers; boot is pending out of reset
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= DCP_IDLE;
      boot_pending <= 1'b1;
      op_write <= 1'b0;
      illegal <= 1'b0;
      o_read_start <= 1'b0;
      o_write_start <= 1'b0;
      o_boot_read <= 1'b0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      boot_pending <= next_boot_pending;
      op_write <= next_op_write;
      illegal <= next_illegal;
      o_read_start <= next_read_start;
      o_write_start <= next_write_start;
      o_boot_read <= next_boot_read;
    end
  end

  // ****************************************************************
  // command and dma address registers
  // ****************************************************************
  logic [1:0] next_drive_sel;
  logic [15:0] next_dma;
  logic next_step;
  logic next_fault_reset;

  // command loads, select latch and clear on op end
  always_comb
  begin
    next_cmd = cmd_load ? wr_cmd : cmd;
    next_drive_sel = o_drive_select;
    next_dma = o_dma_address;
    next_step = cmd_load & wr_cmd.step;
    next_fault_reset = cmd_load & wr_cmd.fault_reset;
    if (cmd_load && wr_cmd.sel_en)
      next_drive_sel = {wr_cmd.sel_hi, wr_cmd.sel_lo};
    if (op_end)
      next_cmd = next_cmd & `DCP_CMD_KEEP_MASK;
    if (dma_lo_load)
      next_dma[7:0] = ~i_host_write_bus_n;
    if (dma_hi_load)
      next_dma[15:8] = ~i_host_write_bus_n;
    if (restart)
    begin
      next_cmd = `DCP_CMD_RESET;
      next_drive_sel = 2'h0;
      next_step = 1'b0;
      next_fault_reset = 1'b0;
    end
  end

  // command registers
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cmd <= `DCP_CMD_RESET;
      o_drive_select <= 2'h0;
      o_dma_address <= `DCP_DMA_RESET;
      o_step_pulse <= 1'b0;
      o_fault_reset <= 1'b0;
    end
    else if (i_ce)
    begin
      cmd <= next_cmd;
      o_drive_select <= next_drive_sel;
      o_dma_address <= next_dma;
      o_step_pulse <= next_step;
      o_fault_reset <= next_fault_reset;
    end
  end

  assign o_step_toward_inner = cmd.dir; // from command flip-flop

  // ****************************************************************
  // status flags
  // ****************************************************************
  logic step_ready;
  logic finished;
  logic next_finished;
  logic track_err;
  logic next_track_err;
  logic id_crc;
  logic next_id_crc;
  logic data_crc;
  logic next_data_crc;
  logic [3:0] rev_count;
  logic [3:0] next_rev_count;
  logic unloaded;

  // settle time after every step command
  dcp_timer #(
    .CYCLES(STEP_READY_CYCLES)
  ) u_step_timer (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_restart(next_step),
    .o_done(step_ready)
  );

  assign unloaded = (rev_count == 4'(UNLOAD_REVS));

  // status byte as seen by the host
  always_comb
  begin
    status_word.drive_fault = i_drive_fault;
    status_word.step_ready = step_ready;
    status_word.track_zero = i_track_zero;
    status_word.finished = finished;
    status_word.track_err = track_err;
    status_word.id_crc = id_crc;
    status_word.data_crc = data_crc;
    status_word.head_unloaded = unloaded | illegal;
  end

  // sticky flags cleared on start; a set in the same cycle wins
  always_comb
  begin
    next_finished = finished & ~op_go;
    next_track_err = track_err & ~op_go;
    next_id_crc = id_crc & ~op_go;
    next_data_crc = data_crc & ~op_go;
    next_rev_count = op_go ? 4'h0 : rev_count;
    if (i_index_pulse && !op_go && !unloaded)
      next_rev_count = rev_count + 4'h1;
    if (state != DCP_IDLE)
    begin
      next_track_err = next_track_err
                       | i_result.track_mismatch;
      next_id_crc = next_id_crc | i_result.id_crc_err;
      next_data_crc = next_data_crc
                      | (i_result.data_crc_err & ~op_write);
    end
    if (op_end)
      next_finished = 1'b1;
    if (restart)
    begin
      next_finished = 1'b0;
      next_track_err = 1'b0;
      next_id_crc = 1'b0;
      next_data_crc = 1'b0;
      next_rev_count = 4'h0;
    end
  end

  // status registers and finished, head lines
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      finished <= 1'b0;
      track_err <= 1'b0;
      id_crc <= 1'b0;
      data_crc <= 1'b0;
      rev_count <= 4'h0;
      o_operation_finished_n <= 1'b1;
      o_head_loaded <= 1'b1;
    end
    else if (i_ce)
    begin
      finished <= next_finished;
      track_err <= next_track_err;
      id_crc <= next_id_crc;
      data_crc <= next_data_crc;
      rev_count <= next_rev_count;
      o_operation_finished_n <= ~next_finished;
      o_head_loaded <= (next_rev_count != 4'(UNLOAD_REVS));
    end
  end

  // ****************************************************************
  // host read bus, three-state by enable
  // ****************************************************************
  logic [7:0] next_read_bus;
  logic next_read_oe;

  // status driven only while a status read is decoded
  always_comb
  begin
    next_read_oe = rd_sel;
    next_read_bus = rd_sel ? status_word : 8'h00;
  end

  // read bus registers, idle value zero with enable low
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_host_read_bus <= 8'h00;
      o_host_read_oe <= 1'b0;
    end
    else if (i_ce)
    begin
      o_host_read_bus <= next_read_bus;
      o_host_read_oe <= next_read_oe;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking dcp_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n || !i_ce);

  read_bus_drive_a: assert property (rd_sel |=> o_host_read_oe
      && o_host_read_bus == $past(status_word))
    else $error("status not driven during read strobe");
  read_bus_float_a: assert property (!rd_sel |=> !o_host_read_oe)
    else $error("read bus driven without matching address");
  cmd_capture_a: assert property (cmd_load && !op_end && !restart
      |=> cmd == $past(wr_cmd))
    else $error("command register did not capture write bus");
  select_keep_a: assert property (cmd_load && !wr_cmd.sel_en
      && !restart |=> $stable(o_drive_select))
    else $error("drive select changed without enable");
  end_clear_a: assert property (op_end && !restart
      |=> (cmd & ~`DCP_CMD_KEEP_MASK) == 8'h00)
    else $error("command bits survived end of operation");
  finish_line_a: assert property (op_end && !restart
      |=> !o_operation_finished_n && status_word.finished)
    else $error("finished not shown after operation end");
  track_abort_a: assert property (state != DCP_IDLE
      && i_result.track_mismatch && !restart
      |=> state == DCP_IDLE && track_err)
    else $error("track mismatch did not abort");
  read_id_crc_a: assert property (state == DCP_BUSY && !op_write
      && i_result.id_crc_err && !i_result.track_mismatch
      && !i_result.op_done && !restart
      |=> state == DCP_BUSY && id_crc)
    else $error("id crc wrongly aborted a read");
  protect_write_a: assert property (start_write && write_blocked
      |=> !o_write_start)
    else $error("write started on protected drive zero");
  illegal_sector_a: assert property (illegal
      |-> status_word.head_unloaded && !status_word.finished)
    else $error("illegal sector status wrong");
  unload_head_a: assert property (unloaded && !op_go && !restart
      |=> !o_head_loaded ##1 !o_head_loaded || $past(op_go || restart))
    else $error("head not unloaded after idle revolutions");

  status_read_c: cover property (rd_sel ##1 o_host_read_oe);
  boot_load_c: cover property (o_boot_read ##[1:20] !o_operation_finished_n);
  write_run_c: cover property (o_write_start ##[1:50] op_end);
  track_error_c: cover property (i_result.track_mismatch && state != DCP_IDLE);

endmodule : dcp_host_port

// >>> rtl/dcp_params.svh
`ifndef DCP_PARAMS_SVH
`define DCP_PARAMS_SVH

// ****************************************************************
// device addresses, decoded from the inverted select bus
// ****************************************************************
`define DCP_ADDR_CMD 8'h7f
`define DCP_ADDR_DMA_HI 8'h7e
`define DCP_ADDR_DMA_LO 8'h7d

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define DCP_BUS_W 8
`define DCP_DMA_W 16
`define DCP_CMD_KEEP_MASK 8'h30
`define DCP_CMD_RESET 8'h00
`define DCP_DMA_RESET 16'h0000
`define DCP_MAX_SECTOR 8'h1a

// ****************************************************************
// timing counts
// ****************************************************************
`define DCP_CLK_MHZ 200
`define DCP_STEP_READY_MS 10
`define DCP_STEP_READY_CYC (`DCP_STEP_READY_MS * 1000 * `DCP_CLK_MHZ)
`define DCP_UNLOAD_REVS 8

`endif

// >>> rtl/dcp_pkg.sv
package dcp_pkg;

  // ****************************************************************
  // controller sequence states, gray along idle-boot-busy
  // ****************************************************************
  typedef enum logic [1:0]
  {
    DCP_IDLE = 2'h0,
    DCP_BOOT = 2'h1,
    DCP_BUSY = 2'h3
  } dcp_state_type;

  // status byte, bit 7 first
  typedef struct packed
  {
    logic head_unloaded;
    logic data_crc;
    logic id_crc;
    logic track_err;
    logic finished;
    logic track_zero;
    logic step_ready;
    logic drive_fault;
  } dcp_status_type;

  // command byte, bit 7 first
  typedef struct packed
  {
    logic write;
    logic read;
    logic sel_hi;
    logic sel_lo;
    logic sel_en;
    logic dir;
    logic step;
    logic fault_reset;
  } dcp_command_type;

  // one-cycle results from the disk engine
  typedef struct packed
  {
    logic op_done;
    logic track_mismatch;
    logic id_crc_err;
    logic data_crc_err;
  } dcp_result_type;

endpackage : dcp_pkg

// >>> rtl/dcp_timer.sv
`timescale 1ns/10ps
module dcp_timer
#(
  parameter int CYCLES = 2000000
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_restart,
  output logic o_done
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_done;

  // count down from restart, done after CYCLES edges
  always_comb
  begin
    next_count = count;
    next_done = o_done;
    if (i_restart)
    begin
      next_count = W'(CYCLES - 1);
      next_done = 1'b0;
    end
    else if (!o_done)
    begin
      if (count == '0)
        next_done = 1'b1;
      else
        next_count = count - 1'b1;
    end
  end

  // registers, frozen while clock enable is low
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      count <= '0;
      o_done <= 1'b1;
    end
    else if (i_ce)
    begin
      count <= next_count;
      o_done <= next_done;
    end
  end

endmodule : dcp_timer

// >>> dv/dcp_host_model.sv
`timescale 1ns/10ps
// ********
// host bus master model
// ********
module dcp_host_model
(
  input wire logic i_clk,
  input wire logic [7:0] i_host_read_bus,
  input wire logic i_host_read_oe,
  output logic [7:0] o_port_select_bus_n,
  output logic [7:0] o_host_write_bus_n,
  output logic o_write_strobe,
  output logic o_read_strobe_n
);
  logic [7:0] last;
  logic [7:0] wire_bus;
  // undriven read bus shows inverse of last value
  assign wire_bus = i_host_read_oe ? i_host_read_bus : ~last;
  // idle bus: no strobe, unused address
  initial
  begin
    last = 8'h00;
    o_port_select_bus_n = 8'hff;
    o_host_write_bus_n = 8'hff;
    o_write_strobe = 1'b0;
    o_read_strobe_n = 1'b1;
  end
  // address, data and strobe together, held two edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_port_select_bus_n <= ~a;
    o_host_write_bus_n <= ~d;
    o_write_strobe <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_write_strobe <= 1'b0;
    o_port_select_bus_n <= 8'hff;
    o_host_write_bus_n <= 8'hff;
    @(posedge i_clk);
  endtask : wr
  // read strobe held until the bus is driven, bounded
  task automatic rd(input logic [7:0] a, output logic ok,
                    output logic [7:0] v);
    int n;
    @(posedge i_clk);
    o_port_select_bus_n <= ~a;
    o_read_strobe_n <= 1'b0;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 6)
    begin
      @(posedge i_clk);
      ok = (i_host_read_oe === 1'b1);
      n++;
    end
    v = wire_bus;
    last = v;
    o_read_strobe_n <= 1'b1;
    o_port_select_bus_n <= 8'hff;
    repeat (2) @(posedge i_clk);
  endtask : rd
endmodule : dcp_host_model

// >>> dv/dcp_host_port_tb.sv
`timescale 1ns/10ps
module dcp_host_port_tb;
  import dcp_pkg::*;
  localparam int STEP_CYC = 20;
  localparam int REVS = 8;
  logic clk, rst_n, ce, boot_n, rstr_n, prot, fault, tz, idx, sv;
  logic [7:0] sec, sel_n, wd_n, rbus;
  dcp_result_type res;
  logic wstb, rstb_n, oe, fin_n, stp, dir, fr, rs, ws, br, hl, ok;
  logic [1:0] sel, s;
  logic [15:0] dma, n_rs, n_ws, n_br, n_st, n_fr;
  logic [7:0] lo, hi, v;
  int miscompares, compares, cyc;
  // ********
  // design and host model
  // ********
  dcp_host_port #(.STEP_READY_CYCLES(STEP_CYC), .UNLOAD_REVS(REVS)) dut
  (
    .i_clk(clk), .i_reset_n(rst_n), .i_ce(ce),
    .i_port_select_bus_n(sel_n), .i_host_write_bus_n(wd_n),
    .i_write_strobe(wstb), .i_read_strobe_n(rstb_n),
    .i_bootstrap_n(boot_n), .i_controller_restart_n(rstr_n),
    .i_drive_zero_write_inhibit(prot), .i_drive_fault(fault),
    .i_track_zero(tz), .i_index_pulse(idx), .i_sector_valid(sv),
    .i_sector_number(sec), .i_result(res), .o_host_read_bus(rbus),
    .o_host_read_oe(oe), .o_operation_finished_n(fin_n),
    .o_drive_select(sel), .o_step_pulse(stp),
    .o_step_toward_inner(dir), .o_fault_reset(fr),
    .o_read_start(rs), .o_write_start(ws), .o_boot_read(br),
    .o_head_loaded(hl), .o_dma_address(dma)
  );
  dcp_host_model host
  (
    .i_clk(clk), .i_host_read_bus(rbus), .i_host_read_oe(oe),
    .o_port_select_bus_n(sel_n), .o_host_write_bus_n(wd_n),
    .o_write_strobe(wstb), .o_read_strobe_n(rstb_n)
  );
  // 200 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // pulse counters and timeout
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rs === 1'b1) n_rs <= n_rs + 16'h0001;
    if (ws === 1'b1) n_ws <= n_ws + 16'h0001;
    if (br === 1'b1) n_br <= n_br + 16'h0001;
    if (stp === 1'b1) n_st <= n_st + 16'h0001;
    if (fr === 1'b1) n_fr <= n_fr + 16'h0001;
    if (cyc == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ********
  // helpers
  // ********
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic sc(input logic u, dc, ic, te, fin, sr);
    host.rd(8'h7f, ok, v);
    chk(ok, 1'b1);
    chk(v, {u, dc, ic, te, fin, tz, sr, fault});
  endtask : sc
  task automatic res_pulse(input dcp_result_type r);
    @(posedge clk);
    res <= r;
    @(posedge clk);
    res <= '0;
    repeat (2) @(posedge clk);
  endtask : res_pulse
  task automatic idx_n(input int n);
    repeat (n)
    begin
      @(posedge clk);
      idx <= 1'b1;
      @(posedge clk);
      idx <= 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask : idx_n
  task automatic tally_and_finish();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // ********
  // main sequence
  // ********
  initial
  begin
    {rst_n, boot_n, rstr_n, prot, fault, tz, idx, sv} = 8'h60;
    ce = 1'b1;
    sec = 8'h00;
    res = '0;
    {n_rs, n_ws, n_br, n_st, n_fr} = '0;
    {miscompares, compares, cyc} = '0;
    void'($urandom(16185));
    repeat (16) @(posedge clk);
    chk({oe, fin_n, hl, sel}, 16'h000c);
    rst_n <= 1'b1;
    fault <= 1'($urandom);
    tz <= 1'($urandom);
    repeat (3) @(posedge clk);
    chk(n_br, 16'h0001);
    res_pulse(4'h8);
    chk(fin_n, 1'b0);
    sc(0, 0, 0, 0, 1, 1);
    // dma bytes and ignored addresses
    repeat (3)
    begin
      lo = 8'($urandom);
      hi = 8'($urandom);
      host.wr(8'h7d, lo);
      host.wr(8'h7e, hi);
      chk(dma, {hi, lo});
    end
    host.wr(8'h7c, ~lo);
    host.wr(8'h80, ~hi);
    chk(dma, {hi, lo});
    host.rd(8'h7e, ok, v);
    chk(ok, 1'b0);
    // read with select, crc errors
    s = 2'($urandom);
    host.wr(8'h7f, {2'b01, s, 4'h8});
    chk(sel, s);
    chk(n_rs, 16'h0001);
    sc(0, 0, 0, 0, 0, 1);
    res_pulse(4'h2);
    sc(0, 0, 1, 0, 0, 1);
    res_pulse(4'h1);
    res_pulse(4'h8);
    sc(0, 1, 1, 0, 1, 1);
    chk(sel, s);
    host.wr(8'h7f, {2'b01, ~s, 4'h0});
    chk(sel, s);
    res_pulse(4'h4);
    sc(0, 0, 0, 1, 1, 1);
    // write aborted by id crc, then drive zero protect
    host.wr(8'h7f, 8'h88);
    chk(n_ws, 16'h0001);
    res_pulse(4'h2);
    sc(0, 0, 1, 0, 1, 1);
    prot <= 1'b1;
    host.wr(8'h7f, 8'h88);
    chk(n_ws, 16'h0001);
    chk(fin_n, 1'b0);
    host.wr(8'h7f, 8'h98);
    chk(n_ws, 16'h0002);
    res_pulse(4'h8);
    prot <= 1'b0;
    // step ready timing and pulses
    tz <= 1'($urandom);
    host.wr(8'h7f, 8'h06);
    chk({n_st[14:0], dir}, 16'h0003);
    sc(0, 0, 0, 0, 1, 0);
    repeat (STEP_CYC) @(posedge clk);
    sc(0, 0, 0, 0, 1, 1);
    host.wr(8'h7f, 8'h01);
    chk(n_fr, 16'h0001);
    // head unload after idle revolutions
    idx_n(REVS - 1);
    sc(0, 0, 0, 0, 1, 1);
    idx_n(1);
    sc(1, 0, 0, 0, 1, 1);
    chk(hl, 1'b0);
    // illegal sector searches forever
    host.wr(8'h7f, 8'h40);
    @(posedge clk);
    sec <= 8'h1b;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    res_pulse(4'h8);
    sc(1, 0, 0, 0, 0, 1);
    // restart and bootstrap
    @(posedge clk);
    rstr_n <= 1'b0;
    repeat (2) @(posedge clk);
    rstr_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(sel, 2'b00);
    chk(n_br, 16'h0002);
    res_pulse(4'h8);
    boot_n <= 1'b0;
    repeat (3) @(posedge clk);
    boot_n <= 1'b1;
    // boot pulse is counted one edge after it shows
    @(posedge clk);
    chk({n_br[14:0], fin_n}, 16'h0007);
    res_pulse(4'h8);
    chk(fin_n, 1'b0);
    tally_and_finish();
  end
endmodule : dcp_host_port_tb
